//--- src/stm_defs.svh
// Register offsets, bit positions, reset values and timing figures of the supply threshold monitor.
`ifndef STM_DEFS_SVH
`define STM_DEFS_SVH

// Register offsets on the plain register port.
`define STM_ADDR_W          4
`define STM_OFS_CONTROL     4'h0
`define STM_OFS_TRIP        4'h1
`define STM_OFS_STATUS      4'h2
`define STM_OFS_CLEAR       4'h3
`define STM_OFS_IRQ_ENABLE  4'h4

// Register data width and reset value of every register.
`define STM_DATA_W          8
`define STM_RESET_BYTE      8'h00

// Field positions inside detect_control_zero.
`define STM_ENABLE_BIT      7
`define STM_OUT_BIT         5
`define STM_READY_BIT       4
`define STM_RISE_BIT        1
`define STM_FALL_BIT        0

// Field position of the event flag in the status, clear and irq enable registers.
`define STM_EVENT_BIT       0

// Trip level select field width, bits 3:0 of trip_level_control.
`define STM_SEL_W           4
`define STM_TRIP_LEVELS     16

// Reference start-up time in ns and the clock period in ns.
`define STM_STARTUP_NS      25000
`define STM_CLOCK_NS        10

`endif

//--- src/stm_pkg.sv
// Types shared by the supply threshold monitor files.
package stm_pkg;

  // Phase of the monitor, Gray coded along off, warm-up, live.
  typedef enum logic [1:0] {
    STM_OFF  = 2'b00,
    STM_WARM = 2'b01,
    STM_LIVE = 2'b11
  } stm_phase_t;

  // One register port request from software.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } stm_bus_req_t;

  // Controls sent to the analog comparator and divider.
  typedef struct packed {
    logic       power;
    logic [3:0] trip_level;
  } stm_analog_t;

endpackage : stm_pkg

//--- src/stm_sync.sv
// Three-stage synchroniser with agreement filter for one asynchronous input.
`timescale 1ns/100ps
module stm_sync
  import stm_pkg::*;
(
  // Clock and reset.
  input  wire logic clock,
  input  wire logic resetn,
  // Asynchronous input and its filtered level.
  input  wire logic async_in,
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } stm_sync_state_t;

  stm_sync_state_t st_reg;
  stm_sync_state_t st_next;

  // The level moves only when the second and third stages agree, so a stage
  // still settling from metastability never reaches the logic behind.
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.level = st_reg.s3;
    end
  end

  // State register.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.level;

endmodule : stm_sync

//--- src/stm_top.sv
// Control, start-up timing, event detection and register file of the supply threshold monitor.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "stm_defs.svh"

// Behaviour
// - Toggling monitor_enable never raises a false event.
// - Read-only reference_ready at control bit 4.
// - Events only when enabled and reference ready.
// - Rise enable flags supply rising above trip.
// - Fall enable flags supply dropping below trip.
// - Both enables flag crossings either way.
// - Readable output bit shows above or below while live; reads zero otherwise.
// - Sixteen trip levels, select bits 3:0.
// - Comparator crossing in enabled direction sets flag.
// - Flag suppressed during reference start-up interval.
// - Control layout: enable7 out5 rise1 fall0.
// - Monitor runs in sleep; event wakes device.
module stm_top
  import stm_pkg::*;
#(
  parameter int TRIP_LEVELS    = `STM_TRIP_LEVELS,
  parameter int STARTUP_CYCLES = (`STM_STARTUP_NS + `STM_CLOCK_NS - 1) / `STM_CLOCK_NS
)
(
  // Clock and reset.
  input  wire logic          clock,
  input  wire logic          resetn,
  // Register port.
  input  wire stm_bus_req_t  bus_req,
  output logic [7:0]         rd_data,
  // Analog comparator side.
  input  wire logic          supply_below,
  output stm_analog_t        analog_ctrl,
  // System side.
  input  wire logic          sleep_mode,
  output logic               irq,
  output logic               wake
);

  localparam int CW = $clog2(STARTUP_CYCLES + 1);

  // Settings that the logic cannot serve are refused at elaboration.
  if (STARTUP_CYCLES < 1) begin : g_bad_startup
    $error("STARTUP_CYCLES must be at least one");
  end
  if (TRIP_LEVELS != (1 << `STM_SEL_W)) begin : g_bad_levels
    $error("TRIP_LEVELS must match the four-bit select field");
  end

  // Whole state of the block.
  typedef struct packed {
    stm_phase_t          phase;
    logic [CW-1:0]       count;
    logic                enable;
    logic                rise_en;
    logic                fall_en;
    logic [`STM_SEL_W-1:0] trip_sel;
    logic                flag;
    logic                irq_en;
    logic                prev_below;
    logic [7:0]          rdata;
    logic                irq;
    logic                wake;
  } stm_state_t;

  stm_state_t st_reg;
  stm_state_t st_next;
  logic       below;
  logic       live;
  logic       rise_evt;
  logic       fall_evt;
  logic       clear_hit;

  // Register address match, used by every write and read path.
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] offset);
    hit = (addr == offset);
  endfunction : hit

  // Read value of the register at an address; unmapped addresses read zero.
  function automatic logic [7:0] read_value(input stm_state_t s, input logic [3:0] addr,
                                            input logic below_now);
    logic [7:0] v;
    v = `STM_RESET_BYTE;
    if (hit(addr, `STM_OFS_CONTROL)) begin
      v[`STM_ENABLE_BIT] = s.enable;
      v[`STM_OUT_BIT]    = (s.phase == STM_LIVE) & s.enable & below_now;
      v[`STM_READY_BIT]  = (s.phase == STM_LIVE);
      v[`STM_RISE_BIT]   = s.rise_en;
      v[`STM_FALL_BIT]   = s.fall_en;
    end else if (hit(addr, `STM_OFS_TRIP)) begin
      v[`STM_SEL_W-1:0] = s.trip_sel;
    end else if (hit(addr, `STM_OFS_STATUS)) begin
      v[`STM_EVENT_BIT] = s.flag;
    end else if (hit(addr, `STM_OFS_IRQ_ENABLE)) begin
      v[`STM_EVENT_BIT] = s.irq_en;
    end
    return v;
  endfunction : read_value

  // The comparator output is asynchronous to the clock and passes the filter.
  stm_sync u_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in (supply_below),
    .level    (below)
  );

  // Events are only looked for once the reference has settled and the enable is on.
  // A supply excursion shorter than the input filter, two clocks, is missed;
  // that is the price of never acting on a half-settled comparator sample.
  always_comb begin
    live      = (st_reg.phase == STM_LIVE) && st_reg.enable;
    rise_evt  = live && st_reg.rise_en && st_reg.prev_below && !below;
    fall_evt  = live && st_reg.fall_en && !st_reg.prev_below && below;
    clear_hit = bus_req.wr && hit(bus_req.addr, `STM_OFS_CLEAR) && bus_req.wdata[`STM_EVENT_BIT];
  end

  // Next state: register writes, start-up sequencing, event capture and outputs.
  always_comb begin
    st_next = st_reg;

    // Software writes.
    if (bus_req.wr) begin
      if (hit(bus_req.addr, `STM_OFS_CONTROL)) begin
        st_next.enable  = bus_req.wdata[`STM_ENABLE_BIT];
        st_next.rise_en = bus_req.wdata[`STM_RISE_BIT];
        st_next.fall_en = bus_req.wdata[`STM_FALL_BIT];
      end
      if (hit(bus_req.addr, `STM_OFS_TRIP)) begin
        st_next.trip_sel = bus_req.wdata[`STM_SEL_W-1:0];
      end
      if (hit(bus_req.addr, `STM_OFS_IRQ_ENABLE)) begin
        st_next.irq_en = bus_req.wdata[`STM_EVENT_BIT];
      end
    end

    // Start-up sequencing. The reference needs a fixed time after power-up, so
    // a wall-clock count gates readiness rather than any settle detection.
    case (st_reg.phase)
      STM_OFF: begin
        st_next.count = '0;
        if (st_reg.enable) begin
          st_next.phase = STM_WARM;
        end
      end
      STM_WARM: begin
        if (!st_reg.enable) begin
          st_next.phase = STM_OFF;
          st_next.count = '0;
        end else if (st_reg.count == CW'(STARTUP_CYCLES - 1)) begin
          st_next.phase = STM_LIVE;
        end else begin
          st_next.count = st_reg.count + CW'(1);
        end
      end
      STM_LIVE: begin
        if (!st_reg.enable) begin
          st_next.phase = STM_OFF;
          st_next.count = '0;
        end
      end
      default: begin
        st_next.phase = STM_OFF;
        st_next.count = '0;
      end
    endcase

    // The baseline follows the comparator at all times, so the first live cycle
    // compares against the present level and an enable edge cannot look like a
    // crossing.
    st_next.prev_below = below;

    // Sticky flag; a new event in the clearing cycle wins over the clear.
    st_next.flag = (st_reg.flag && !clear_hit) || rise_evt || fall_evt;

    // Read data stands for the one cycle after the read strobe.
    st_next.rdata = bus_req.rd ? read_value(st_reg, bus_req.addr, below) : `STM_RESET_BYTE;

    // Outputs follow the stored bits they are made from.
    st_next.irq  = st_next.flag && st_next.irq_en;
    st_next.wake = st_next.flag && sleep_mode;
  end

  // State register.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // All outputs come straight from the state register.
  assign rd_data                = st_reg.rdata;
  assign irq                    = st_reg.irq;
  assign wake                   = st_reg.wake;
  assign analog_ctrl            = '{power: st_reg.enable, trip_level: st_reg.trip_sel};

  // Helper for checks: cycles since the stored enable went high, saturating.
  int unsigned en_age;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      en_age <= 0;
    end else if (!st_reg.enable) begin
      en_age <= 0;
    end else if (en_age < 32'hFFFF_FFFF) begin
      en_age <= en_age + 1;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  // Enable edge followed by warm-up with the ready bit low.
  sequence s_enable_edge;
    $rose(st_reg.enable);
  endsequence

  sequence s_warm_not_ready;
    (st_reg.phase == STM_WARM) && (st_reg.count == '0);
  endsequence

  enable_no_event_a: assert property ($rose(st_reg.enable) || $fell(st_reg.enable) |=> !$rose(st_reg.flag))
    else $error("event flag rose on an enable change");

  warmup_start_a: assert property (s_enable_edge |-> (st_reg.phase == STM_OFF) ##1 s_warm_not_ready)
    else $error("warm-up did not follow the enable edge");

  ready_timing_a: assert property ($rose(st_reg.phase == STM_LIVE) |-> en_age == STARTUP_CYCLES + 1)
    else $error("reference ready at the wrong time after enable");

  event_gate_a: assert property ($rose(st_reg.flag) |-> $past(st_reg.phase) == STM_LIVE && $past(st_reg.enable))
    else $error("event flag set while not enabled and ready");

  rise_flag_a: assert property (rise_evt |=> st_reg.flag)
    else $error("rising crossing not flagged");

  fall_flag_a: assert property (fall_evt |=> st_reg.flag)
    else $error("falling crossing not flagged");

  direction_cause_a: assert property ($rose(st_reg.flag) |-> $past(rise_evt) || $past(fall_evt))
    else $error("event flag rose without an enabled crossing");

  out_read_a: assert property (bus_req.rd && hit(bus_req.addr, `STM_OFS_CONTROL)
                               |=> rd_data[`STM_OUT_BIT] == $past(live && below))
    else $error("output bit read back wrong");

  trip_write_a: assert property (bus_req.wr && hit(bus_req.addr, `STM_OFS_TRIP)
                                 |=> analog_ctrl.trip_level == $past(bus_req.wdata[`STM_SEL_W-1:0]))
    else $error("trip level not taken from the write");

  flag_sticky_a: assert property (st_reg.flag && !clear_hit |=> st_reg.flag)
    else $error("event flag dropped without a clear");

  sleep_wake_a: assert property ((rise_evt || fall_evt) && sleep_mode |=> wake)
    else $error("crossing in sleep did not wake");

  read_once_a: assert property (!bus_req.rd |=> rd_data == 8'h00)
    else $error("read data stood beyond its cycle");

  // Disabling takes the reference down one cycle after the stored enable drops,
  // so ready outlives the power to the divider by that one cycle.
  sequence s_enable_drop;
    $fell(st_reg.enable);
  endsequence

  sequence s_back_off;
    (st_reg.phase == STM_OFF) && (st_reg.count == '0);
  endsequence

  ready_drop_a: assert property (s_enable_drop |=> s_back_off)
    else $error("monitor stayed up after the enable dropped");

  // The ready bit reads high exactly once the full interval has passed since enable.
  ready_read_a: assert property (bus_req.rd && hit(bus_req.addr, `STM_OFS_CONTROL)
                                 |=> rd_data[`STM_READY_BIT] == ($past(en_age) > STARTUP_CYCLES))
    else $error("ready bit read back at the wrong time");

  // Live is only reached after the whole start-up interval with the enable on.
  ready_window_a: assert property (st_reg.phase == STM_LIVE |-> en_age > STARTUP_CYCLES)
    else $error("monitor went live before the start-up interval ended");

  // The warm-up counter never passes its end point, whatever the enable does.
  warm_count_a: assert property (st_reg.phase == STM_WARM |-> st_reg.count < CW'(STARTUP_CYCLES))
    else $error("warm-up count ran past the start-up time");

  // Off parks the counter at zero, so every enable starts a full interval.
  off_count_a: assert property (st_reg.phase == STM_OFF |-> st_reg.count == '0)
    else $error("warm-up count not parked while off");

  // Raw crossings of the filtered comparator level, whatever the direction enables say.
  sequence s_went_above;
    live && st_reg.prev_below && !below;
  endsequence

  sequence s_went_below;
    live && !st_reg.prev_below && below;
  endsequence

  rise_off_a: assert property (s_went_above ##0 !st_reg.rise_en |=> !$rose(st_reg.flag))
    else $error("rising crossing flagged with its direction off");

  fall_off_a: assert property (s_went_below ##0 !st_reg.fall_en |=> !$rose(st_reg.flag))
    else $error("falling crossing flagged with its direction off");

  // A clear with no crossing in the same cycle empties the flag.
  sequence s_plain_clear;
    clear_hit && !rise_evt && !fall_evt;
  endsequence

  clear_flag_a: assert property (s_plain_clear |=> !st_reg.flag)
    else $error("clear did not empty the event flag");

  // Writes to the status offset leave the flag to the hardware alone.
  status_ro_a: assert property (bus_req.wr && hit(bus_req.addr, `STM_OFS_STATUS)
                                |=> st_reg.flag == ($past(st_reg.flag) || $past(rise_evt) || $past(fall_evt)))
    else $error("status write changed the event flag");

  // The interrupt line is the flag masked by its enable, with no extra lag.
  irq_level_a: assert property (irq == (st_reg.flag && st_reg.irq_en))
    else $error("interrupt line disagrees with flag and enable");

  // A wake request only ever follows a cycle spent asleep.
  wake_sleep_a: assert property (wake |-> $past(sleep_mode))
    else $error("wake raised while awake");

  // Comparator power follows the enable bit of the last control write.
  power_write_a: assert property (bus_req.wr && hit(bus_req.addr, `STM_OFS_CONTROL)
                                  |=> analog_ctrl.power == $past(bus_req.wdata[`STM_ENABLE_BIT]))
    else $error("enable bit not taken from the control write");

  // Direction enables sit at their own control bits.
  dir_write_a: assert property (bus_req.wr && hit(bus_req.addr, `STM_OFS_CONTROL)
                                |=> st_reg.rise_en == $past(bus_req.wdata[`STM_RISE_BIT])
                                    && st_reg.fall_en == $past(bus_req.wdata[`STM_FALL_BIT]))
    else $error("direction enables not taken from the control write");

  // The divider tap only moves on a write to the trip level register.
  trip_hold_a: assert property (!(bus_req.wr && hit(bus_req.addr, `STM_OFS_TRIP))
                                |=> $stable(analog_ctrl.trip_level))
    else $error("trip level moved without a write");

  // Offsets beyond the map read back as zero.
  unmapped_read_a: assert property (bus_req.rd && (bus_req.addr > `STM_OFS_IRQ_ENABLE)
                                    |=> rd_data == `STM_RESET_BYTE)
    else $error("unmapped offset read back non-zero");

endmodule : stm_top

//--- tb/stm_top_tb.sv
// Self-checking testbench of the supply threshold monitor, driven over its register port.
`timescale 1ns/100ps
`include "stm_defs.svh"
module stm_top_tb
  import stm_pkg::*;
;
  // Short warm-up keeps the run brief while leaving room to cross inside it.
  localparam int WARM = 40;

  logic         clock;
  logic         resetn;
  stm_bus_req_t bus_req;
  logic [7:0]   rd_data;
  logic         supply_below;
  stm_analog_t  analog_ctrl;
  logic         sleep_mode;
  logic         irq;
  logic         wake;
  int           mismatches;
  int           comparisons;

  stm_top #(.TRIP_LEVELS(16), .STARTUP_CYCLES(WARM)) u_dut (
    .clock        (clock),
    .resetn       (resetn),
    .bus_req      (bus_req),
    .rd_data      (rd_data),
    .supply_below (supply_below),
    .analog_ctrl  (analog_ctrl),
    .sleep_mode   (sleep_mode),
    .irq          (irq),
    .wake         (wake)
  );

  // Free-running system clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write strobe, then the port goes idle.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample at its middle.
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus_req <= '0;
    @(negedge clock);
    chk(rd_data, exp);
  endtask : rdchk

  // Moves the comparator level and allows the filter and flag latency to pass.
  task automatic swing(input logic v);
    @(posedge clock);
    supply_below <= v;
    repeat (10) @(posedge clock);
  endtask : swing

  // Disable first, then trip level, directions and enable in one write, stale flag clear, and warm-up.
  task automatic arm(input logic [1:0] m);
    wr(`STM_OFS_CONTROL, 8'h00);
    wr(`STM_OFS_TRIP, 8'h05);
    wr(`STM_OFS_CONTROL, {6'h20, m});
    wr(`STM_OFS_CLEAR, 8'h01);
    repeat (WARM + 5) @(posedge clock);
  endtask : arm

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // A hang counts as a mismatch and ends the run the usual way.
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    end_sim;
  end

  // Main sequence.
  initial begin
    resetn = 1'b0;
    bus_req = '0;
    supply_below = 1'b0;
    sleep_mode = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    // Reset values, including unmapped offsets above the map.
    for (int a = 0; a < 8; a++) begin
      rdchk(a[3:0], 8'h00);
    end
    chk({3'h0, analog_ctrl}, 8'h00);
    // Every trip level reaches the divider; upper bits read zero.
    for (int l = 0; l < 16; l++) begin
      wr(`STM_OFS_TRIP, 8'hF0 | l[7:0]);
      rdchk(`STM_OFS_TRIP, l[7:0]);
      chk({4'h0, analog_ctrl.trip_level}, l[7:0]);
    end
    // Crossings during warm-up are lost; ready appears only after it.
    wr(`STM_OFS_CONTROL, 8'h83);
    rdchk(`STM_OFS_CONTROL, 8'h83);
    chk({7'h00, analog_ctrl.power}, 8'h01);
    swing(1'b1);
    swing(1'b0);
    repeat (WARM) @(posedge clock);
    rdchk(`STM_OFS_CONTROL, 8'h93);
    rdchk(`STM_OFS_STATUS, 8'h00);
    // Each direction mode against a fall and a rise.
    for (int m = 1; m < 4; m++) begin
      arm(m[1:0]);
      swing(1'b1);
      rdchk(`STM_OFS_CONTROL, 8'hB0 | m[7:0]);
      rdchk(`STM_OFS_STATUS, {7'h00, m[0]});
      wr(`STM_OFS_CLEAR, 8'h01);
      rdchk(`STM_OFS_STATUS, 8'h00);
      swing(1'b0);
      rdchk(`STM_OFS_STATUS, {7'h00, m[1]});
      rdchk(`STM_OFS_STATUS, {7'h00, m[1]});
      wr(`STM_OFS_CLEAR, 8'h01);
    end
    // Interrupt and wake while asleep; status ignores writes.
    wr(`STM_OFS_IRQ_ENABLE, 8'h01);
    rdchk(`STM_OFS_IRQ_ENABLE, 8'h01);
    @(posedge clock);
    sleep_mode <= 1'b1;
    swing(1'b1);
    @(negedge clock);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, wake}, 8'h01);
    wr(`STM_OFS_STATUS, 8'h00);
    rdchk(`STM_OFS_STATUS, 8'h01);
    wr(`STM_OFS_CLEAR, 8'h01);
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk({6'h00, irq, wake}, 8'h00);
    // Masked interrupt keeps the flag but not the line.
    wr(`STM_OFS_IRQ_ENABLE, 8'h00);
    swing(1'b0);
    rdchk(`STM_OFS_STATUS, 8'h01);
    chk({7'h00, irq}, 8'h00);
    // Toggling the enable with the supply below must not flag.
    swing(1'b1);
    wr(`STM_OFS_CLEAR, 8'h01);
    wr(`STM_OFS_CONTROL, 8'h00);
    wr(`STM_OFS_CONTROL, 8'h83);
    repeat (WARM + 5) @(posedge clock);
    rdchk(`STM_OFS_STATUS, 8'h00);
    wr(`STM_OFS_CONTROL, 8'h03);
    rdchk(`STM_OFS_STATUS, 8'h00);
    rdchk(`STM_OFS_CONTROL, 8'h03);
    // A crossing while disabled is ignored.
    swing(1'b0);
    rdchk(`STM_OFS_STATUS, 8'h00);
    end_sim;
  end
endmodule : stm_top_tb
